// File: ingress_event_pkg.sv
package ingress_event_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses
  localparam logic [7:0] CTRL_BASE   = 8'h00;  // One control word per counter, stride 4
  localparam logic [7:0] COUNT_BASE  = 8'h20;  // Low word then high word, stride 8
  localparam logic [7:0] STATUS_ADDR = 8'h40;  // Overflow and activity flags
  localparam int unsigned CTRL_STRIDE  = 4;
  localparam int unsigned COUNT_STRIDE = 8;
  localparam int unsigned HI_WORD_OFS  = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Control word layout
  localparam int unsigned EVENT_LSB = 0;
  localparam int unsigned EVENT_W   = 8;
  localparam int unsigned MASK_LSB  = 8;
  localparam int unsigned MASK_W    = 8;
  localparam int unsigned CTRL_W    = 16;
  localparam logic [15:0] CTRL_RESET = 16'h0000;

  // Status word layout
  localparam int unsigned STAT_OVF_LSB = 0;
  localparam int unsigned STAT_ACT_LSB = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Event codes
  localparam logic [7:0] EV_BYPASS_COUNT          = 8'h40;
  localparam logic [7:0] EV_NONEMPTY_CYCLES_ZERO  = 8'h43;
  localparam logic [7:0] EV_ARB_NO_CREDIT_ZERO    = 8'h47;
  localparam logic [7:0] EV_ARB_NO_CREDIT_ONE     = 8'h48;
  localparam logic [7:0] EV_ARB_NOT_ASKING_ZERO   = 8'h49;
  localparam logic [7:0] EV_ARB_NOT_ASKING_ONE    = 8'h4A;
  localparam logic [7:0] EV_CREDIT_MISC           = 8'h5F;
  localparam logic [7:0] EV_CREDIT_OCCUPANCY      = 8'h60;

  ////////////////////////////////////////////////////////////////////////////
  // Sub-select layout and limits
  localparam int unsigned CLASS_W          = 7;  // Message classes, bits 0..6
  localparam int unsigned BYPASS_W         = 4;  // Bypass sub-conditions, bits 0..3
  localparam int unsigned CRD_MISC_W       = 6;  // Credit misc sub-conditions, bits 0..5
  localparam int unsigned OCC_POOL_BIT     = 0;
  localparam int unsigned OCC_FIFO_BIT     = 1;
  localparam int unsigned BYPASS_LAST_CTR  = 2;  // Bypass counts on counters 0..2 only
  localparam int unsigned DCC_LIMIT_ONE    = 1;
  localparam int unsigned DCC_LIMIT_TWO    = 2;
  localparam logic [31:0] COUNT_RESET      = 32'h0000_0000;

endpackage : ingress_event_pkg

// File: ingress_event_select.sv
module ingress_event_select
  import ingress_event_pkg::*;
#(
  parameter int unsigned COUNTER_IDX = 0,
  parameter int unsigned OCC_W       = 8,
  parameter int unsigned DCC_W       = 4
) (
  input  wire logic [ingress_event_pkg::EVENT_W-1:0] event_code,
  input  wire logic [ingress_event_pkg::MASK_W-1:0]  sub_mask,
  input  wire logic [ingress_event_pkg::CLASS_W-1:0] no_credit_zero,
  input  wire logic [ingress_event_pkg::CLASS_W-1:0] no_credit_one,
  input  wire logic [ingress_event_pkg::CLASS_W-1:0] not_asking_zero,
  input  wire logic [ingress_event_pkg::CLASS_W-1:0] not_asking_one,
  input  wire logic                                  arb_won_other,
  input  wire logic [ingress_event_pkg::CLASS_W-1:0] nonempty_zero,
  input  wire logic [ingress_event_pkg::BYPASS_W-1:0] bypass_taken,
  input  wire logic                                  ccf_fifo_busy,
  input  wire logic                                  ccf_path_busy,
  input  wire logic                                  dcc_blocked_zero,
  input  wire logic                                  dcc_blocked_one,
  input  wire logic [DCC_W-1:0]                      dcc_count,
  input  wire logic [OCC_W-1:0]                      pool_in_use,
  input  wire logic [OCC_W-1:0]                      ccf_occupancy,
  output logic      [OCC_W:0]                        increment
);

  logic                  hit;
  logic [OCC_W:0]        amount;
  logic [CRD_MISC_W-1:0] misc_cond;
  logic                  bypass_allowed;

  // Only the low counters may carry the bypass event
  assign bypass_allowed = (COUNTER_IDX <= BYPASS_LAST_CTR);

  // Credit misc sub-conditions in sub-select bit order
  assign misc_cond = {dcc_count < DCC_W'(DCC_LIMIT_TWO),
                      dcc_count < DCC_W'(DCC_LIMIT_ONE),
                      dcc_blocked_one,
                      dcc_blocked_zero,
                      ccf_path_busy,
                      ccf_fifo_busy};

  // Event decode, any selected sub-condition counts once; occupancy adds its selected values
  always_comb begin
    hit    = 1'b0;
    amount = '0;
    case (event_code)
      EV_ARB_NO_CREDIT_ZERO: begin
        hit = |(sub_mask[CLASS_W-1:0] & no_credit_zero);
      end
      EV_ARB_NO_CREDIT_ONE: begin
        hit = |(sub_mask[CLASS_W-1:0] & no_credit_one);
      end
      EV_ARB_NOT_ASKING_ZERO: begin
        hit = arb_won_other & |(sub_mask[CLASS_W-1:0] & not_asking_zero);
      end
      EV_ARB_NOT_ASKING_ONE: begin
        hit = arb_won_other & |(sub_mask[CLASS_W-1:0] & not_asking_one);
      end
      EV_BYPASS_COUNT: begin
        hit = bypass_allowed & |(sub_mask[BYPASS_W-1:0] & bypass_taken);
      end
      EV_CREDIT_MISC: begin
        hit = |(sub_mask[CRD_MISC_W-1:0] & misc_cond);
      end
      EV_CREDIT_OCCUPANCY: begin
        // Both selections add together in one cycle
        amount = (sub_mask[OCC_POOL_BIT] ? {1'b0, pool_in_use} : '0)
               + (sub_mask[OCC_FIFO_BIT] ? {1'b0, ccf_occupancy} : '0);
      end
      EV_NONEMPTY_CYCLES_ZERO: begin
        hit = |(sub_mask[CLASS_W-1:0] & nonempty_zero);
      end
      default: begin
        hit    = 1'b0;
        amount = '0;
      end
    endcase
  end

  assign increment = hit ? (OCC_W+1)'(1) : amount;

endmodule : ingress_event_select

// File: ingress_event_filter.sv
// Functional notes
// - Code 0x48 counts one-side credit-blocked arbitration requests
// - Code 0x47 counts zero-side credit-blocked arbitration requests
// - Code 0x49 counts zero-side no-request while other wins
// - Code 0x4A counts one-side no-request while other wins
// - Sub-select bits 0-6 choose message classes
// - Code 0x40 counts bypasses, counters 0-2 only
// - Bypass bits 0-3 choose slot and pipeline situation
// - Code 0x5F bits 0-1 flag fifo or path occupancy
// - Code 0x5F bits 2-3 flag completion-credit blocking
// - Code 0x5F bits 4-5 flag completion credits below 1/2
// - Code 0x60 adds pool credits and fifo occupancy
// - Code 0x43 counts zero-side ingress non-empty cycles
// - Each counter has its own event and sub-select
//
// Register map, byte addresses, counter i
// 0x00 + 4i: control, [7:0] event code, [15:8] sub-select
// 0x20 + 8i: count bits 31:0, a write loads this half
// 0x24 + 8i: count bits 47:32, the rest reads as zero
// 0x40 [3:0]: sticky overflow, write one to clear
// 0x40 [19:16]: counter advanced in the previous cycle
// Unmapped or misaligned addresses answer with an error
//
// Timing
// Every access ends in its first access cycle
// Read data is taken at the setup edge
// A count read shows the value before that edge
// A control write steers counting from the next cycle
// A counter load wins over an increment in that cycle
// Counter activity shows one cycle after the count
// Overflow set wins over a clear in the same cycle
// Reading low then high word is not atomic
//
// Limits
// An unknown event code counts nothing
// The bypass event counts on counters 0 to 2 only
// Sub-select bit 7 is ignored by every event
// A zero sub-select never counts
// Occupancy adds up to two values in one cycle
// An occupancy sum cannot overflow the increment
// A write to an unmapped address changes nothing
//
// The APB interface to the registers and the placing of the registers were decided locally.
module ingress_event_filter
  import ingress_event_pkg::*;
#(
  parameter int unsigned CTR_N = 4,
  parameter int unsigned CNT_W = 48,
  parameter int unsigned OCC_W = 8,
  parameter int unsigned DCC_W = 4
) (
  input  wire logic                                   clk_sys,
  input  wire logic                                   reset_n,
  // APB slave
  input  wire logic                                   psel,
  input  wire logic                                   penable,
  input  wire logic                                   pwrite,
  input  wire logic [ingress_event_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [ingress_event_pkg::DATA_W-1:0]   pwdata,
  output logic      [ingress_event_pkg::DATA_W-1:0]   prdata,
  output logic                                        pready,
  output logic                                        pslverr,
  // Ingress condition inputs
  input  wire logic [ingress_event_pkg::CLASS_W-1:0]  no_credit_zero,
  input  wire logic [ingress_event_pkg::CLASS_W-1:0]  no_credit_one,
  input  wire logic [ingress_event_pkg::CLASS_W-1:0]  not_asking_zero,
  input  wire logic [ingress_event_pkg::CLASS_W-1:0]  not_asking_one,
  input  wire logic                                   arb_won_other,
  input  wire logic [ingress_event_pkg::CLASS_W-1:0]  nonempty_zero,
  input  wire logic [ingress_event_pkg::BYPASS_W-1:0] bypass_taken,
  input  wire logic                                   ccf_fifo_busy,
  input  wire logic                                   ccf_path_busy,
  input  wire logic                                   dcc_blocked_zero,
  input  wire logic                                   dcc_blocked_one,
  input  wire logic [DCC_W-1:0]                       dcc_count,
  input  wire logic [OCC_W-1:0]                       pool_in_use,
  input  wire logic [OCC_W-1:0]                       ccf_occupancy,
  // Counter activity, one bit per counter
  output logic      [CTR_N-1:0]                       counter_active
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  // Per-counter control and counts
  logic [CTRL_W-1:0]  ctrl_r      [CTR_N];
  logic [CTRL_W-1:0]  ctrl_nxt    [CTR_N];
  logic [CNT_W-1:0]   count_r     [CTR_N];
  logic [CNT_W-1:0]   count_nxt   [CTR_N];
  logic [OCC_W:0]     increment   [CTR_N];

  // Status flags and wrap marks
  logic [CTR_N-1:0]   ovf_r;
  logic [CTR_N-1:0]   ovf_nxt;
  logic [CTR_N-1:0]   act_r;
  logic [CTR_N-1:0]   act_nxt;
  logic [CTR_N-1:0]   wrap;

  // Bus decode
  logic [CTR_N-1:0]   sel_ctrl;
  logic [CTR_N-1:0]   sel_lo;
  logic [CTR_N-1:0]   sel_hi;
  logic               sel_status;
  logic               addr_hit;
  logic               setup_phase;
  logic               wr_access;

  // Read path
  logic [DATA_W-1:0]  rd_value;
  logic [DATA_W-1:0]  prdata_r;
  logic [DATA_W-1:0]  prdata_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // APB handshake, zero wait states

  // Every access completes in its first access cycle
  assign pready      = 1'b1;

  // Phase qualifiers; writes need a mapped address
  assign setup_phase = psel & ~penable;
  assign wr_access   = psel & penable & pwrite & addr_hit;

  // Error and read data towards the master
  assign pslverr     = psel & penable & ~addr_hit;  // Unmapped or misaligned
  assign prdata      = prdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  // Per-counter register selects
  generate
    for (genvar gi = 0; gi < CTR_N; gi++) begin : g_decode
      assign sel_ctrl[gi] = (paddr == ADDR_W'(CTRL_BASE + gi * CTRL_STRIDE));
      assign sel_lo[gi]   = (paddr == ADDR_W'(COUNT_BASE + gi * COUNT_STRIDE));
      assign sel_hi[gi]   = (paddr == ADDR_W'(COUNT_BASE + gi * COUNT_STRIDE
                                               + HI_WORD_OFS));
    end
  endgenerate

  // Status word and overall hit
  assign sel_status = (paddr == STATUS_ADDR);
  assign addr_hit   = |sel_ctrl | |sel_lo | |sel_hi | sel_status;

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  // Read value mux, unmapped reads as zero
  always_comb begin
    rd_value = '0;
    for (int i = 0; i < CTR_N; i++) begin
      if (sel_ctrl[i]) begin
        rd_value = DATA_W'(ctrl_r[i]);
      end
      if (sel_lo[i]) begin
        rd_value = count_r[i][DATA_W-1:0];
      end
      if (sel_hi[i]) begin
        rd_value = DATA_W'(count_r[i] >> DATA_W);
      end
    end
    if (sel_status) begin
      rd_value = (DATA_W'(ovf_r) << STAT_OVF_LSB)
               | (DATA_W'(act_r) << STAT_ACT_LSB);
    end
  end

  // Read data is captured at the setup edge and held through access
  always_comb begin
    prdata_nxt = prdata_r;
    if (setup_phase) begin
      prdata_nxt = rd_value;
    end
  end

  // Read data register
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      prdata_r <= COUNT_RESET;
    end else begin
      prdata_r <= prdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-counter control, event select and counting

  generate
    for (genvar gi = 0; gi < CTR_N; gi++) begin : g_counter
      logic [EVENT_W-1:0] event_sel;
      logic [MASK_W-1:0]  mask_sel;

      // Fields of this counter's control word
      assign event_sel = ctrl_r[gi][EVENT_LSB +: EVENT_W];
      assign mask_sel  = ctrl_r[gi][MASK_LSB +: MASK_W];

      // Independent event and sub-select for this counter
      ingress_event_select #(
        .COUNTER_IDX (gi),
        .OCC_W       (OCC_W),
        .DCC_W       (DCC_W)
      ) ingress_event_select_i (
        .event_code       (event_sel),
        .sub_mask         (mask_sel),
        .no_credit_zero   (no_credit_zero),
        .no_credit_one    (no_credit_one),
        .not_asking_zero  (not_asking_zero),
        .not_asking_one   (not_asking_one),
        .arb_won_other    (arb_won_other),
        .nonempty_zero    (nonempty_zero),
        .bypass_taken     (bypass_taken),
        .ccf_fifo_busy    (ccf_fifo_busy),
        .ccf_path_busy    (ccf_path_busy),
        .dcc_blocked_zero (dcc_blocked_zero),
        .dcc_blocked_one  (dcc_blocked_one),
        .dcc_count        (dcc_count),
        .pool_in_use      (pool_in_use),
        .ccf_occupancy    (ccf_occupancy),
        .increment        (increment[gi])
      );

      // Control word write
      always_comb begin
        ctrl_nxt[gi] = ctrl_r[gi];
        if (wr_access && sel_ctrl[gi]) begin
          ctrl_nxt[gi] = pwdata[CTRL_W-1:0];
        end
      end

      // Counter advance; a software load wins over counting
      always_comb begin
        count_nxt[gi] = count_r[gi] + CNT_W'(increment[gi]);
        wrap[gi]      = (count_nxt[gi] < count_r[gi]);
        if (wr_access && sel_lo[gi]) begin
          count_nxt[gi] = {count_r[gi][CNT_W-1:DATA_W], pwdata};
          wrap[gi]      = 1'b0;
        end
        if (wr_access && sel_hi[gi]) begin
          count_nxt[gi] = {pwdata[CNT_W-DATA_W-1:0], count_r[gi][DATA_W-1:0]};
          wrap[gi]      = 1'b0;
        end
      end

      // Control register
      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          ctrl_r[gi] <= CTRL_RESET;
        end else begin
          ctrl_r[gi] <= ctrl_nxt[gi];
        end
      end

      // Counter register
      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          count_r[gi] <= CNT_W'(COUNT_RESET);
        end else begin
          count_r[gi] <= count_nxt[gi];
        end
      end

    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Status flags

  // Sticky overflow, write one to clear; a new wrap wins over the clear
  always_comb begin
    ovf_nxt = ovf_r;
    if (wr_access && sel_status) begin
      ovf_nxt = ovf_r & ~pwdata[STAT_OVF_LSB +: CTR_N];
    end
    ovf_nxt = ovf_nxt | wrap;
  end

  // Overflow flags
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ovf_r <= '0;
    end else begin
      ovf_r <= ovf_nxt;
    end
  end

  // Activity, one cycle behind the increment that caused it
  always_comb begin
    act_nxt = '0;
    for (int i = 0; i < CTR_N; i++) begin
      act_nxt[i] = (increment[i] != '0);
    end
  end

  // Activity flags
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      act_r <= '0;
    end else begin
      act_r <= act_nxt;
    end
  end

  // Activity leaves the block straight from its flops
  assign counter_active = act_r;

endmodule : ingress_event_filter

// File: ingress_event_filter_checker.sv
module ingress_event_filter_checker
  import ingress_event_pkg::*;
#(
  parameter int unsigned CTR_N = 4,
  parameter int unsigned OCC_W = 8,
  parameter int unsigned DCC_W = 4
) (
  input wire logic clk_sys, reset_n, psel, penable, pwrite, pready, pslverr,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [CLASS_W-1:0] no_credit_zero, no_credit_one, nonempty_zero,
  input wire logic [CLASS_W-1:0] not_asking_zero, not_asking_one,
  input wire logic arb_won_other, ccf_fifo_busy, ccf_path_busy,
  input wire logic dcc_blocked_zero, dcc_blocked_one,
  input wire logic [BYPASS_W-1:0] bypass_taken,
  input wire logic [DCC_W-1:0] dcc_count,
  input wire logic [OCC_W-1:0] pool_in_use, ccf_occupancy,
  input wire logic [CTR_N-1:0] counter_active
);
  logic [15:0] c0_r, c0_nxt, c3_r, c3_nxt;
  logic [7:0]  hit, ev;
  logic [6:0]  mk;
  logic        mapped;

  // Shadow of control words 0 and 3
  always_comb begin
    c0_nxt = c0_r;
    c3_nxt = c3_r;
    if (psel && penable && pwrite && paddr == 8'h00) c0_nxt = pwdata[15:0];
    if (psel && penable && pwrite && paddr == 8'h0C) c3_nxt = pwdata[15:0];
  end

  // Shadow registers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      c0_r <= '0;
      c3_r <= '0;
    end else begin
      c0_r <= c0_nxt;
      c3_r <= c3_nxt;
    end
  end

  // Address decode and expected hit of counter 0 per event
  always_comb begin
    ev = c0_r[7:0];
    mk = c0_r[14:8];
    mapped = paddr[1:0] == 2'b00 && (paddr < 4 * CTR_N || paddr == 8'h40 ||
             (paddr >= 8'h20 && paddr < 8'h20 + 8 * CTR_N));
    hit[0] = |(no_credit_zero & mk);
    hit[1] = |(no_credit_one & mk);
    hit[2] = arb_won_other && |(not_asking_zero & mk);
    hit[3] = arb_won_other && |(not_asking_one & mk);
    hit[4] = |(nonempty_zero & mk);
    hit[5] = |(bypass_taken & mk[3:0]);
    hit[6] = |(mk[5:0] & {dcc_count < 2, dcc_count < 1, dcc_blocked_one,
                          dcc_blocked_zero, ccf_path_busy, ccf_fifo_busy});
    hit[7] = (mk[0] && pool_in_use != 0) || (mk[1] && ccf_occupancy != 0);
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  a_ready_high: assert property (pready)
    else $error("pready low");
  a_err_map: assert property (psel && penable |-> pslverr == !mapped)
    else $error("pslverr wrong");
  a_active_reset: assert property ($rose(reset_n) |-> counter_active == '0)
    else $error("activity after reset");
  a_no_credit_zero: assert property (ev == 8'h47 |=> counter_active[0] == $past(hit[0]))
    else $error("no credit zero");
  a_no_credit_one: assert property (ev == 8'h48 |=> counter_active[0] == $past(hit[1]))
    else $error("no credit one");
  a_not_ask_zero: assert property (ev == 8'h49 |=> counter_active[0] == $past(hit[2]))
    else $error("not asking zero");
  a_not_ask_one: assert property (ev == 8'h4A |=> counter_active[0] == $past(hit[3]))
    else $error("not asking one");
  a_nonempty_zero: assert property (ev == 8'h43 |=> counter_active[0] == $past(hit[4]))
    else $error("nonempty zero");
  a_bypass_hit: assert property (ev == 8'h40 |=> counter_active[0] == $past(hit[5]))
    else $error("bypass count");
  a_bypass_gone: assert property (c3_r[7:0] == 8'h40 |=> !counter_active[3])
    else $error("bypass on counter 3");
  a_credit_misc: assert property (ev == 8'h5F |=> counter_active[0] == $past(hit[6]))
    else $error("credit misc");
  a_credit_occ: assert property (ev == 8'h60 |=> counter_active[0] == $past(hit[7]))
    else $error("credit occupancy");
  a_mask_zero: assert property (mk == 7'h00 |=> !counter_active[0])
    else $error("empty mask counted");

  // Main scenarios reached
  cover property (ev == 8'h43 && hit[4]);
  cover property (ev == 8'h5F && hit[6]);
  cover property (c3_r[7:0] == 8'h40 && bypass_taken != 0);
endmodule : ingress_event_filter_checker

// File: ingress_event_filter_tb.sv
module ingress_event_filter_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ingress_event_pkg::*;

  logic        clk_sys, reset_n, psel, penable, pwrite, pready, pslverr, er;
  logic        arb_won_other, ccf_fifo_busy, ccf_path_busy, dcc_blocked_zero, dcc_blocked_one;
  logic [6:0]  no_credit_zero, no_credit_one, not_asking_zero, not_asking_one, nonempty_zero;
  logic [7:0]  paddr, pool_in_use, ccf_occupancy;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  bypass_taken, dcc_count, counter_active;
  int          fail_count, num_checks;

  ingress_event_filter ingress_event_filter_i (
    .clk_sys, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .no_credit_zero, .no_credit_one, .not_asking_zero, .not_asking_one,
    .arb_won_other, .nonempty_zero, .bypass_taken, .ccf_fifo_busy, .ccf_path_busy,
    .dcc_blocked_zero, .dcc_blocked_one, .dcc_count, .pool_in_use, .ccf_occupancy,
    .counter_active
  );

  // System clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task stop_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  task hold(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : hold

  // One APB transfer, waits for pready under a bound
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
    end
    if (n == 16) begin
      fail_count++;
      stop_test();
    end
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb

  // Quiet inputs; two completion credits is not below either limit
  task idle();
    {no_credit_zero, no_credit_one, not_asking_zero, not_asking_one, nonempty_zero} <= '0;
    {arb_won_other, bypass_taken, ccf_fifo_busy, ccf_path_busy} <= '0;
    {dcc_blocked_zero, dcc_blocked_one, pool_in_use, ccf_occupancy} <= '0;
    dcc_count <= 4'h2;
  endtask : idle

  task prog(input int c, input logic [7:0] code, input logic [7:0] m);
    apb(1'b1, 8'(4 * c), {16'h0000, m, code});
    apb(1'b1, 8'(8'h20 + 8 * c), 32'h0000_0000);
  endtask : prog

  task want(input int c, input int e);
    idle();
    apb(1'b0, 8'(8'h20 + 8 * c), 32'h0000_0000);
    chk(rd, 32'(e));
  endtask : want

  task set_misc(input logic [5:0] v);
    {ccf_fifo_busy, ccf_path_busy, dcc_blocked_zero, dcc_blocked_one} <= {v[0], v[1], v[2], v[3]};
    dcc_count <= v[4] ? 4'h0 : (v[5] ? 4'h1 : 4'h2);
  endtask : set_misc

  ////////////////////////////////////////////////////////////////////////////
  // Reset values, unmapped and misaligned places, unused control bits
  task t_regs();
    for (int a = 0; a < 'h48; a += 4) begin
      apb(1'b0, 8'(a), 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      chk({31'h0, er}, {31'h0, (a >= 'h10 && a < 'h20) || a == 'h44});
    end
    apb(1'b1, 8'h02, 32'h0000_FFFF);
    chk({31'h0, er}, 32'h0000_0001);
    apb(1'b1, 8'h00, 32'hFFFF_FFFF);
    apb(1'b0, 8'h00, 32'h0000_0000);
    chk(rd, 32'h0000_FFFF);
  endtask : t_regs

  // Each class bit alone, then bit 7 alone and full masks
  task t_class();
    for (int k = 0; k < 7; k++) begin
      prog(0, 8'h43, 8'(1 << k));
      nonempty_zero <= 7'h7F ^ 7'(1 << k);
      hold(2);
      nonempty_zero <= 7'(1 << k);
      hold(3);
      want(0, 3);
    end
    for (int m = 0; m < 2; m++) begin
      prog(0, 8'h43, m ? 8'h7F : 8'h80);
      nonempty_zero <= 7'h7F;
      hold(4);
      want(0, m * 4);
    end
  endtask : t_class

  // Credit and request events on counters 0 and 1
  task t_arb();
    logic [7:0] codes [4];
    codes = '{8'h47, 8'h48, 8'h49, 8'h4A};
    for (int i = 0; i < 4; i++) begin
      prog(0, codes[i], 8'h05);
      prog(1, codes[i], 8'h05);
      {no_credit_zero, no_credit_one, not_asking_zero, not_asking_one} <= {4{7'h7A}};
      arb_won_other <= 1'b1;
      hold(2);
      no_credit_zero <= (i == 0) ? 7'h04 : 7'h00;
      no_credit_one <= (i == 1) ? 7'h04 : 7'h00;
      not_asking_zero <= (i == 2) ? 7'h04 : 7'h00;
      not_asking_one <= (i == 3) ? 7'h04 : 7'h00;
      arb_won_other <= 1'b0;
      hold(2);
      arb_won_other <= 1'b1;
      hold(2);
      want(0, i < 2 ? 4 : 2);
      want(1, i < 2 ? 4 : 2);
    end
  endtask : t_arb

  // Bypass on counters 0, 2 and 3 at once
  task t_bypass();
    prog(0, 8'h40, 8'h0C);
    prog(2, 8'h40, 8'h0C);
    prog(3, 8'h40, 8'h0F);
    bypass_taken <= 4'h3;
    hold(2);
    bypass_taken <= 4'h4;
    hold(3);
    bypass_taken <= 4'h8;
    hold(1);
    want(2, 4);
    want(3, 0);
    want(0, 4);
    prog(2, 8'h40, 8'h03);
    bypass_taken <= 4'hC;
    hold(2);
    bypass_taken <= 4'h1;
    hold(2);
    want(2, 2);
  endtask : t_bypass

  // Credit misc bits one by one, credit limits at their boundary
  task t_misc();
    for (int b = 0; b < 6; b++) begin
      prog(0, 8'h5F, 8'(1 << b));
      set_misc(6'h2F & ~6'(1 << b));
      hold(2);
      set_misc(6'(1 << b));
      hold(3);
      want(0, 3);
    end
  endtask : t_misc

  // Occupancy sums for masks 1, 2 and 3
  task t_occ();
    for (int m = 1; m < 4; m++) begin
      prog(0, 8'h60, 8'(m));
      {pool_in_use, ccf_occupancy} <= {8'hFF, 8'h07};
      hold(3);
      want(0, 3 * ((m & 1) * 255 + (m >> 1) * 7));
    end
  endtask : t_occ

  // Counter wrap across both words, sticky overflow and its clear
  task t_wrap();
    prog(1, 8'h43, 8'h01);
    apb(1'b1, 8'h2C, 32'h0000_FFFF);
    apb(1'b1, 8'h28, 32'hFFFF_FFFF);
    nonempty_zero <= 7'h01;
    hold(2);
    want(1, 1);
    apb(1'b0, 8'h2C, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk(rd, 32'h0000_0002);
    apb(1'b1, 8'h40, 32'h0000_0002);
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
  endtask : t_wrap

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, paddr, pwdata} <= '0;
    idle();
    reset_n <= 1'b0;
    hold(16);
    reset_n <= 1'b1;
    t_regs();
    t_class();
    t_arb();
    t_bypass();
    t_misc();
    t_occ();
    t_wrap();
    reset_n <= 1'b0;
    hold(2);
    reset_n <= 1'b1;
    want(2, 0);
    stop_test();
  end
endmodule : ingress_event_filter_tb

bind ingress_event_filter ingress_event_filter_checker #(
  .CTR_N(CTR_N), .OCC_W(OCC_W), .DCC_W(DCC_W)
) ingress_event_filter_checker_i (
  .clk_sys, .reset_n, .psel, .penable, .pwrite, .pready, .pslverr, .paddr, .pwdata,
  .no_credit_zero, .no_credit_one, .nonempty_zero, .not_asking_zero, .not_asking_one,
  .arb_won_other, .ccf_fifo_busy, .ccf_path_busy, .dcc_blocked_zero, .dcc_blocked_one,
  .bypass_taken, .dcc_count, .pool_in_use, .ccf_occupancy, .counter_active
);
